// >>> hdl/ref_temp_pkg.sv
package ref_temp_pkg;

  // Register byte offsets on the Avalon-MM slave.
  localparam logic [15:0] CTRL_OFFSET   = 16'h100c;
  localparam logic [15:0] TCALC_OFFSET  = 16'h1010;
  localparam logic [15:0] TRES_OFFSET   = 16'h1014;
  localparam logic [15:0] GAINS_OFFSET  = 16'h1018;
  localparam logic [15:0] OFFS_OFFSET   = 16'h101c;
  localparam logic [15:0] STAT_OFFSET   = 16'h1020;

  // Field positions in the shared control register.
  localparam int EN_BIT     = 7;
  localparam int RDY_BIT    = 6;
  localparam int TSON_BIT   = 5;
  localparam int RANGE_BIT  = 4;
  localparam int BUF2_LSB   = 2;
  localparam int BUF1_LSB   = 0;

  // Reset values.
  localparam logic [7:0]  CTRL_RESET   = 8'h00;
  localparam logic [15:0] GAIN_RESET   = 16'h0000;
  localparam logic [15:0] OFFSET_RESET = 16'h0000;

  // Conversion constants.
  localparam int GAIN_SHIFT   = 8;
  localparam int TEMP_DIVISOR = 10;
  localparam int DIV_STEPS    = 24;

  // Reference settling time in ns and its cycle count at 125 MHz (rounded up).
  localparam int SETTLE_NS     = 25000;
  localparam int CLK_PERIOD_NS = 8;
  localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Buffer gain codes.
  typedef enum logic [1:0] {
    BUF_OFF = 2'h0,
    BUF_X1  = 2'h1,
    BUF_X2  = 2'h2,
    BUF_X4  = 2'h3
  } buf_gain_t;

endpackage

// >>> hdl/temp_divider.sv
`timescale 1ns/10ps
// Signed restoring divider by a constant; the quotient truncates toward zero
// like integer division in software, and comes out of a register.
module temp_divider #(
  parameter int WIDTH = 24
) (
  input  wire logic                    mclk,
  input  wire logic                    rst,
  input  wire logic                    start,
  input  wire logic signed [WIDTH-1:0] dividend,
  output logic signed [WIDTH-1:0]      quotient_r,
  output logic                         done_r
);

  localparam logic [4:0] DIVISOR = 5'(ref_temp_pkg::TEMP_DIVISOR);

  logic [WIDTH-1:0] mag_r;
  logic [4:0]       rem_r;
  logic [5:0]       cnt_r;
  logic             neg_r;
  logic             busy_r;
  logic [5:0]       trial;
  wire  [WIDTH-1:0] abs_in;

  // Work on the magnitude so negative results truncate toward zero.
  assign abs_in = dividend[WIDTH-1] ? WIDTH'(-dividend) : dividend;
  assign trial  = {rem_r, mag_r[WIDTH-1]};

  // One quotient bit per clock.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mag_r <= '0; rem_r <= '0; cnt_r <= '0; neg_r <= 1'b0;
      busy_r <= 1'b0; done_r <= 1'b0; quotient_r <= '0;
    end else begin
      done_r <= 1'b0;
      if (start) begin
        mag_r <= abs_in; rem_r <= '0; neg_r <= dividend[WIDTH-1];
        cnt_r <= 6'(WIDTH); busy_r <= 1'b1;
      end else if (busy_r) begin
        if (trial >= {1'b0, DIVISOR}) begin
          rem_r <= 5'(trial - {1'b0, DIVISOR});
          mag_r <= {mag_r[WIDTH-2:0], 1'b1};
        end else begin
          rem_r <= trial[4:0];
          mag_r <= {mag_r[WIDTH-2:0], 1'b0};
        end
        cnt_r <= cnt_r - 6'h01;
        if (cnt_r == 6'h01) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
          quotient_r <= neg_r ? -$signed({mag_r[WIDTH-2:0], trial >= {1'b0, DIVISOR}})
                              : $signed({mag_r[WIDTH-2:0], trial >= {1'b0, DIVISOR}});
        end
      end
    end
  end

endmodule

// >>> hdl/ref_temp_ctrl.sv
`timescale 1ns/10ps
// Summary of operation
// - Bit 7 enables the fixed reference; resets to zero.
// - Bit 6 is a read-only ready flag, zero when reference disabled or settling.
// - Bit 5 enables the temperature sensor; resets to zero.
// - Bit 4 selects high (1) or low (0) sensor range; resets to zero.
// - Bits 3:2 set buffer 2 gain: off, 1x, 2x, 4x; reset off.
// - Bits 1:0 set buffer 1 gain with same codes; reset off.
// - Buffer 2 feeds converter, comparator and ADC input only, never reference.
// - Buffer 1 feeds ADC reference and an ADC input channel.
// - One register holds reference and sensor fields; each write with byte lane 0 enabled rewrites all.
// - Sensor draws no current while its enable bit is clear.
module ref_temp_ctrl #(
  parameter int SETTLE_COUNT = ref_temp_pkg::SETTLE_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [15:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic             fixed_voltage_ref_on,
  output logic             temp_sensor_on,
  output logic             temp_range_select,
  output logic [1:0]       buffer1_gain_select,
  output logic [1:0]       buffer2_gain_select,
  output logic             buf1_to_adc_ref,
  output logic             buf1_to_adc_chan,
  output logic             buf2_to_dac_cmp,
  output logic             buf2_to_adc_chan
);

  //////////////////////////////////////////////////////////////////////////////
  // Registers and decode.

  logic [7:0]         ctrl_r;
  logic               rdy_r;
  logic [15:0]        settle_cnt_r;
  logic [15:0]        adc_r;
  logic [15:0]        gain_lo_r;
  logic [15:0]        gain_hi_r;
  logic [15:0]        off_lo_r;
  logic [15:0]        off_hi_r;
  logic signed [23:0] temp_r;
  logic               busy_r;
  logic               start_r;
  logic               ack_r;
  logic [31:0]        rdata_r;
  logic [7:0]         ctrl_nxt;
  logic signed [23:0] quot;
  logic               div_done;

  wire req          = (avs_read | avs_write) & ~ack_r;
  wire wr           = avs_write & ack_r;  // Lands only where waitrequest is seen low.
  wire hit_ctrl     = avs_address == ref_temp_pkg::CTRL_OFFSET;
  wire hit_tcalc    = avs_address == ref_temp_pkg::TCALC_OFFSET;
  wire hit_gains    = avs_address == ref_temp_pkg::GAINS_OFFSET;
  wire hit_offs     = avs_address == ref_temp_pkg::OFFS_OFFSET;
  wire range_hi     = ctrl_r[ref_temp_pkg::RANGE_BIT];
  wire ref_en       = ctrl_r[ref_temp_pkg::EN_BIT];

  // Merge bytes of a 16-bit pair under the byte enables.
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw,
                                          input logic [1:0] be);
    merge16 = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
  endfunction

  // A whole-byte write replaces every field at once, the ready bit excepted.
  assign ctrl_nxt = {avs_writedata[7], 1'b0, avs_writedata[5:0]};

  // Pick the calibration constants by range.
  wire signed [15:0] gain_sel = range_hi ? gain_hi_r : gain_lo_r;
  wire signed [15:0] off_sel  = range_hi ? off_hi_r  : off_lo_r;
  wire signed [39:0] product  = $signed({1'b0, adc_r}) * gain_sel;
  wire signed [23:0] scaled   = 24'(product >>> ref_temp_pkg::GAIN_SHIFT);
  wire signed [23:0] pre_div  = scaled + 24'(off_sel);

  //////////////////////////////////////////////////////////////////////////////
  // Bus slave: one wait cycle, answer on the second edge.

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ack_r <= 1'b0;
      avs_waitrequest <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end else begin
      ack_r <= req;
      // A registered copy keeps the port glitch free and straight off a flop.
      avs_waitrequest <= ~req;
      if (avs_read & ~ack_r) begin
        case (1'b1)
          hit_ctrl:  rdata_r <= {24'h00_0000, ctrl_r[7], rdy_r & ref_en, ctrl_r[5:0]};
          hit_tcalc: rdata_r <= {16'h0000, adc_r};
          avs_address == ref_temp_pkg::TRES_OFFSET: rdata_r <= 32'(temp_r);
          hit_gains: rdata_r <= {gain_hi_r, gain_lo_r};
          hit_offs:  rdata_r <= {off_hi_r, off_lo_r};
          avs_address == ref_temp_pkg::STAT_OFFSET: rdata_r <= {31'h0, busy_r};
          default:   rdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign avs_readdata    = rdata_r;

  // Control register and calibration writes.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_r    <= ref_temp_pkg::CTRL_RESET;
      gain_lo_r <= ref_temp_pkg::GAIN_RESET;
      gain_hi_r <= ref_temp_pkg::GAIN_RESET;
      off_lo_r  <= ref_temp_pkg::OFFSET_RESET;
      off_hi_r  <= ref_temp_pkg::OFFSET_RESET;
    end else if (wr) begin
      if (hit_ctrl && avs_byteenable[0]) ctrl_r <= ctrl_nxt;
      if (hit_gains) begin
        gain_lo_r <= merge16(gain_lo_r, avs_writedata[15:0], avs_byteenable[1:0]);
        gain_hi_r <= merge16(gain_hi_r, avs_writedata[31:16], avs_byteenable[3:2]);
      end
      if (hit_offs) begin
        off_lo_r <= merge16(off_lo_r, avs_writedata[15:0], avs_byteenable[1:0]);
        off_hi_r <= merge16(off_hi_r, avs_writedata[31:16], avs_byteenable[3:2]);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Reference settling: ready rises once the reference has been on long enough.

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      settle_cnt_r <= 16'h0000;
      rdy_r <= 1'b0;
    end else if (!ref_en) begin
      settle_cnt_r <= 16'h0000;
      rdy_r <= 1'b0;
    end else if (settle_cnt_r < 16'(SETTLE_COUNT - 1)) begin
      settle_cnt_r <= settle_cnt_r + 16'h0001;
    end else begin
      rdy_r <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Conversion: writing the raw reading starts a calculation. Software owns the
  // averaging and acquisition wait; this engine just does the arithmetic.

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      adc_r <= 16'h0000;
      start_r <= 1'b0;
      busy_r <= 1'b0;
      temp_r <= '0;
    end else begin
      start_r <= 1'b0;
      if (wr && hit_tcalc && !busy_r) begin
        // Byte 1 is the high result byte and byte 0 the low one.
        adc_r <= {avs_writedata[15:8], avs_writedata[7:0]};
        start_r <= 1'b1;
        busy_r <= 1'b1;
      end else if (div_done) begin
        temp_r <= quot;
        busy_r <= 1'b0;
      end
    end
  end

  temp_divider #(.WIDTH(24)) u_div (
    .mclk       (mclk),
    .rst        (rst),
    .start      (start_r),
    .dividend   (pre_div),
    .quotient_r (quot),
    .done_r     (div_done)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Analog controls, all from flip-flops.

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fixed_voltage_ref_on <= 1'b0;
      temp_sensor_on <= 1'b0;
      temp_range_select <= 1'b0;
      buffer1_gain_select <= 2'h0;
      buffer2_gain_select <= 2'h0;
      buf1_to_adc_ref <= 1'b0;
      buf1_to_adc_chan <= 1'b0;
      buf2_to_dac_cmp <= 1'b0;
      buf2_to_adc_chan <= 1'b0;
    end else begin
      fixed_voltage_ref_on <= ref_en;
      temp_sensor_on <= ctrl_r[ref_temp_pkg::TSON_BIT];
      temp_range_select <= range_hi;
      buffer1_gain_select <= ctrl_r[ref_temp_pkg::BUF1_LSB +: 2];
      buffer2_gain_select <= ctrl_r[ref_temp_pkg::BUF2_LSB +: 2];
      buf1_to_adc_ref  <= ctrl_r[1:0] != ref_temp_pkg::BUF_OFF;
      buf1_to_adc_chan <= ctrl_r[1:0] != ref_temp_pkg::BUF_OFF;
      buf2_to_dac_cmp  <= ctrl_r[3:2] != ref_temp_pkg::BUF_OFF;
      buf2_to_adc_chan <= ctrl_r[3:2] != ref_temp_pkg::BUF_OFF;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks.

  property p_en_follows;
    @(posedge mclk) disable iff (rst) $past(ref_en) == fixed_voltage_ref_on;
  endproperty
  a_en_follows: assert property (p_en_follows) else $error("enable output lags bit");

  property p_rdy_off;
    @(posedge mclk) disable iff (rst) !ref_en |=> !rdy_r;
  endproperty
  a_rdy_off: assert property (p_rdy_off) else $error("ready while disabled");

  property p_sensor;
    @(posedge mclk) disable iff (rst) !ctrl_r[5] |=> !temp_sensor_on;
  endproperty
  a_sensor: assert property (p_sensor) else $error("sensor on while disabled");

  property p_range;
    @(posedge mclk) disable iff (rst) range_hi |=> temp_range_select;
  endproperty
  a_range: assert property (p_range) else $error("range output wrong");

  property p_buf2;
    @(posedge mclk) disable iff (rst) ##1 buffer2_gain_select == $past(ctrl_r[3:2]);
  endproperty
  a_buf2: assert property (p_buf2) else $error("buffer 2 gain wrong");

  property p_buf1;
    @(posedge mclk) disable iff (rst) buf1_to_adc_ref == (buffer1_gain_select != 2'h0);
  endproperty
  a_buf1: assert property (p_buf1) else $error("buffer 1 routing wrong");

  property p_buf2_route;
    @(posedge mclk) disable iff (rst)
      (ctrl_r[3:2] != 2'h0) |=> (buf2_to_adc_chan && buf2_to_dac_cmp);
  endproperty
  a_buf2_route: assert property (p_buf2_route) else $error("buffer 2 routing wrong");

  property p_ctrl_write;
    @(posedge mclk) disable iff (rst) wr && hit_ctrl && avs_byteenable[0]
      |=> ctrl_r == {$past(avs_writedata[7]), 1'b0, $past(avs_writedata[5:0])};
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

  property p_calc_done;
    @(posedge mclk) disable iff (rst) start_r |-> ##[24:26] !busy_r;
  endproperty
  a_calc_done: assert property (p_calc_done) else $error("calculation too slow");

endmodule

// >>> verif/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic        mclk;
  logic        rst;
  logic [15:0] avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        fixed_voltage_ref_on;
  logic        temp_sensor_on;
  logic        temp_range_select;
  logic [1:0]  buffer1_gain_select;
  logic [1:0]  buffer2_gain_select;
  logic        buf1_to_adc_ref;
  logic        buf1_to_adc_chan;
  logic        buf2_to_dac_cmp;
  logic        buf2_to_adc_chan;
  int          avg;
  logic [7:0]  v;
  int          bad_count;
  int          checks;
  // Sensor acquisition wait in clocks; a plain value chosen for simulation.
  localparam int ACQ_CYCLES = 4;

  ref_temp_ctrl #(.SETTLE_COUNT(4)) i_ref_temp_ctrl (
    .mclk(mclk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .fixed_voltage_ref_on(fixed_voltage_ref_on), .temp_sensor_on(temp_sensor_on),
    .temp_range_select(temp_range_select), .buffer1_gain_select(buffer1_gain_select),
    .buffer2_gain_select(buffer2_gain_select), .buf1_to_adc_ref(buf1_to_adc_ref),
    .buf1_to_adc_chan(buf1_to_adc_chan), .buf2_to_dac_cmp(buf2_to_dac_cmp),
    .buf2_to_adc_chan(buf2_to_adc_chan)
  );

  // The clock toggles every half period of 8 ns.
  always #4 mclk = ~mclk;

  ////////////////////////////////////////////////////////////////////////////
  // Verdict and comparison helpers.
  task automatic final_report();
    $display("checks %0d, mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // One Avalon-MM access; the request is held until waitrequest is seen low.
  // A spare edge follows the release so that no signal is assigned twice at once.
  task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] rd);
    int n;
    n = 0;
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    avs_read       <= !wr;
    avs_write      <= wr;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      bad_count++;
      $display("unexpected at %0t: no answer on the bus", $time);
      final_report();
    end
    @(posedge mclk);
  endtask

  task automatic wr32(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    bus(1'b1, a, d, 4'hf, dummy);
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    bus(1'b0, a, 32'h0000_0000, 4'hf, rd);
    check(rd, exp);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Expected temperature is worked out here with plain integer arithmetic.
  // Division by 256 floors, division by 10 truncates toward zero.
  task automatic calc(input logic rng, input logic [15:0] adc, input logic [15:0] gl,
                      input logic [15:0] gh, input logic [15:0] ol, input logic [15:0] oh,
                      input bit dup);
    int p;
    int n;
    logic [31:0] rd;
    p = int'(adc) * int'($signed(rng ? gh : gl));
    p = (p >>> 8) + int'($signed(rng ? oh : ol));
    p = p / 10;
    wr32(16'h100c, {26'h0, 1'b1, rng, 4'h0});
    wr32(16'h1018, {gh, gl});
    wr32(16'h101c, {oh, ol});
    rd_chk(16'h1018, {gh, gl});
    repeat (ACQ_CYCLES) @(posedge mclk);
    wr32(16'h1010, {16'h0, adc});
    if (dup) begin
      wr32(16'h1010, {16'h0, ~adc}); // A start while busy is ignored.
    end
    n = 0;
    do begin
      bus(1'b0, 16'h1020, 32'h0000_0000, 4'hf, rd);
      n++;
    end while (rd[0] !== 1'b0 && n < 40);
    check(rd[0], 1'b0);
    if (rd[0] !== 1'b0) begin
      final_report();
    end
    rd_chk(16'h1014, 32'(p));
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    avs_address = 16'h0000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'h0;
    bad_count = 0;
    checks = 0;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rd_chk(16'h100c, 32'h0000_0000);
    check({fixed_voltage_ref_on, temp_sensor_on, buf1_to_adc_ref, buf2_to_dac_cmp}, 4'h0);
    $display("test reset done");
    // The ready bit cannot be written and stays low while disabled.
    wr32(16'h100c, 32'h0000_0040);
    rd_chk(16'h100c, 32'h0000_0000);
    wr32(16'h100c, 32'h0000_0080);
    rd_chk(16'h100c, 32'h0000_0080);
    repeat (8) @(posedge mclk);
    rd_chk(16'h100c, 32'h0000_00c0);
    check(fixed_voltage_ref_on, 1'b1);
    wr32(16'h100c, 32'h0000_0000);
    repeat (2) @(posedge mclk);
    rd_chk(16'h100c, 32'h0000_0000);
    $display("test ready done");
    // Every value of bits 5:0, each write replacing the whole register.
    for (int i = 0; i < 64; i++) begin
      v = 8'(i);
      wr32(16'h100c, {24'h0, v});
      rd_chk(16'h100c, {24'h0, v});
      check({temp_sensor_on, temp_range_select}, v[5:4]);
      check({buffer2_gain_select, buffer1_gain_select}, v[3:0]);
      check({buf1_to_adc_ref, buf1_to_adc_chan}, {2{v[1:0] != 2'h0}});
      check({buf2_to_dac_cmp, buf2_to_adc_chan}, {2{v[3:2] != 2'h0}});
    end
    $display("test fields done");
    // A write without the low byte lane, and unmapped places.
    wr32(16'h100c, 32'h0000_0000);
    begin : lane_test
      logic [31:0] dummy;
      bus(1'b1, 16'h100c, 32'h0000_0025, 4'he, dummy);
    end
    rd_chk(16'h100c, 32'h0000_0000);
    wr32(16'h1030, 32'hffff_ffff);
    rd_chk(16'h1030, 32'h0000_0000);
    rd_chk(16'h100c, 32'h0000_0000);
    $display("test refusals done");
    calc(1'b0, 16'h0312, 16'h012c, 16'hff00, 16'hfe0c, 16'h0400, 1'b0);
    calc(1'b1, 16'h0200, 16'h0050, 16'hfeb3, 16'h0010, 16'h0100, 1'b0);
    calc(1'b0, 16'h03ff, 16'hfff9, 16'h0020, 16'h0003, 16'hff00, 1'b1);
    // Ten readings are averaged in software before the conversion is asked for.
    avg = 0;
    for (int k = 0; k < 10; k++) avg += 16'h0300 + k;
    calc(1'b1, 16'(avg / 10), 16'h0120, 16'h0140, 16'hfe00, 16'hfd80, 1'b0);
    $display("test calculation done");
    // A second reset clears the register and the outputs again.
    wr32(16'h100c, 32'h0000_00bf);
    rst <= 1'b1;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rd_chk(16'h100c, 32'h0000_0000);
    check({fixed_voltage_ref_on, buffer1_gain_select, buffer2_gain_select}, 5'h00);
    $display("test second reset done");
    final_report();
  end
endmodule
